// *** rtl/ppl_consts.svh ***
// Constants for the parasite-power sensor link: command codes, timing and reset values.
`ifndef PPL_CONSTS_SVH
`define PPL_CONSTS_SVH

`define CMD_CONVERT 8'h44
`define CMD_COPY 8'h48
`define CMD_WRITE 8'h4e
`define CMD_READ 8'hbe
`define CMD_ALARM 8'hec

`define CLK_MHZ 125
`define CONV_MS 750
`define COPY_MS 10
`define SPU_US 10
`define CONV_CYC (`CONV_MS * 1000 * `CLK_MHZ)
`define COPY_CYC (`COPY_MS * 1000 * `CLK_MHZ)
`define SPU_CYC (`SPU_US * `CLK_MHZ)
`define RSP_WAIT_CYC 16

`define TEMP_RST 16'h0550
`define TH_RST 8'h7f
`define TL_RST 8'h80
`define CFG_RST 8'h60
`define CFG_RES_LO 5
`define CFG_RES_HI 6
`define DATA_TH_HI 23
`define DATA_TH_LO 16
`define DATA_TL_HI 15
`define DATA_TL_LO 8
`define DATA_CFG_HI 7
`define DATA_CFG_LO 0

`endif

// *** rtl/ppl_pkg.sv ***
// Types and the shared conversion-time function of the parasite-power sensor link.
`default_nettype none
package ppl_pkg;
   typedef logic [7:0] cmd_t;
   typedef logic [63:0] rom_t;
   typedef logic [1:0] res_t;

   typedef enum logic [1:0] {
      D_IDLE = 2'b00,
      D_CONV = 2'b01,
      D_COPY = 2'b10
   } dev_state_t;

   typedef enum logic [1:0] {
      M_IDLE = 2'b00,
      M_SEND = 2'b01,
      M_HOLD = 2'b10,
      M_WAIT = 2'b11
   } mst_state_t;

   // Conversion time scales by half for each bit of resolution dropped.
   function automatic logic [31:0] conv_cycles(input logic [31:0] full, input res_t res);
      conv_cycles = full >> (2'd3 - res);
   endfunction
endpackage
`default_nettype wire

// *** rtl/ppl_link_if.sv ***
// Command-level link between the bus master and the parasite-powered sensor.
`default_nettype none
interface ppl_link_if;
   import ppl_pkg::*;
   logic cmd_vld;
   cmd_t cmd_code;
   rom_t cmd_rom;
   logic [23:0] cmd_data;
   logic spu_en;
   logic rsp_vld;
   logic [63:0] rsp_data;

   modport master_mp (output cmd_vld, output cmd_code, output cmd_rom, output cmd_data, output spu_en,
                      input rsp_vld, input rsp_data);
   modport device_mp (input cmd_vld, input cmd_code, input cmd_rom, input cmd_data, input spu_en,
                      output rsp_vld, output rsp_data);
endinterface
`default_nettype wire

// *** rtl/ppl_sensor_dev.sv ***
// Parasite-powered temperature sensor end of the link.
`include "ppl_consts.svh"
`default_nettype none

// Notes on behaviour
// [R1] Master turns on strong pullup within 10 us.
// [R2] Pullup held through conversion or 10 ms copy.
// [R3] No bus traffic while pullup is on.
// [R4] Device selected by its unique 64-bit code.
// [R5] 12-bit conversion finishes within 750 ms.
// [R6] Resolution selectable as 9 to 12 bits.
// [R7] Alarm search answered only when alarm set.
// [R8] One-byte alarm limits kept in nonvolatile store.
// [R9] Two-byte temperature register holds each result.
// [R10] Idle until convert command, then store, idle.
// [R11] Copy command alone commits limits and configuration.
// [R12] Pullup released only after full hold time.
module ppl_sensor_dev #(
   // Code that selects this device; the default value is arbitrary.
   parameter logic [63:0] ROM_ID = 64'h0123456789abcdef,
   parameter int unsigned CONV_CYC = `CONV_CYC,
   parameter int unsigned COPY_CYC = `COPY_CYC
) (
   input wire logic CORE_CLK_I,
   input wire logic NRST_I,
   ppl_link_if.device_mp LINK,
   input wire logic [15:0] SENSOR_I,
   output logic BUSY_O,
   output logic ALARM_O,
   output logic POWER_FAULT_O,
   output logic [15:0] TEMP_O
);
   import ppl_pkg::*;

   // ==========================================================
   // State
   dev_state_t state_r, state_nxt;
   logic [31:0] cnt_r, cnt_nxt;
   logic [15:0] temp_r, temp_nxt;
   logic [7:0] th_r, th_nxt;
   logic [7:0] tl_r, tl_nxt;
   logic [7:0] cfg_r, cfg_nxt;
   // Nonvolatile copies of the limits and the configuration.
   logic [7:0] ee_th_r, ee_th_nxt;
   logic [7:0] ee_tl_r, ee_tl_nxt;
   logic [7:0] ee_cfg_r, ee_cfg_nxt;
   logic alarm_r, alarm_nxt;
   logic fault_r, fault_nxt;
   logic rsp_vld_r, rsp_vld_nxt;
   logic [63:0] rsp_data_r, rsp_data_nxt;

   // ==========================================================
   // Command decode
   logic selected;
   logic search_hit;
   res_t res;
   logic [15:0] sample;
   logic signed [7:0] whole;

   assign selected = LINK.cmd_vld && (LINK.cmd_rom == ROM_ID); // R4
   // An alarm search carries no device code, so only the alarm flag decides whether to answer.
   assign search_hit = LINK.cmd_vld && (LINK.cmd_code == `CMD_ALARM) && alarm_r; // R7
   assign res = cfg_r[`CFG_RES_HI:`CFG_RES_LO]; // R6

   always_comb begin
      sample = SENSOR_I;
      // Bits below the selected resolution read as zero.
      case (res)
         2'd0: sample[2:0] = 3'h0;
         2'd1: sample[1:0] = 2'h0;
         2'd2: sample[0] = 1'b0;
         default: sample = SENSOR_I;
      endcase
   end

   assign whole = sample[11:4];

   // ==========================================================
   // Limit test
   // Only the whole-degree byte of the result meets the one-byte signed limits.
   logic alarm_hit;

   assign alarm_hit = (whole > $signed(th_r)) || (whole < $signed(tl_r)); // R7

   // ==========================================================
   // Next state
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      temp_nxt = temp_r;
      th_nxt = th_r;
      tl_nxt = tl_r;
      cfg_nxt = cfg_r;
      ee_th_nxt = ee_th_r;
      ee_tl_nxt = ee_tl_r;
      ee_cfg_nxt = ee_cfg_r;
      alarm_nxt = alarm_r;
      fault_nxt = fault_r;
      // Answers are one-cycle pulses.
      rsp_vld_nxt = 1'b0;
      rsp_data_nxt = rsp_data_r;
      case (state_r)
         D_IDLE: begin
            if (search_hit) begin
               rsp_vld_nxt = 1'b1; // R7
               rsp_data_nxt = ROM_ID; // R7
            end
            if (selected) begin
               // A power fault stays visible until the next command addressed to this device.
               fault_nxt = 1'b0;
               case (LINK.cmd_code)
                  `CMD_CONVERT: begin
                     state_nxt = D_CONV; // R10
                     // Loaded one short so that the last powered cycle sees zero.
                     cnt_nxt = conv_cycles(CONV_CYC, res) - 32'd1; // R5
                  end
                  `CMD_COPY: begin
                     state_nxt = D_COPY; // R11
                     cnt_nxt = COPY_CYC - 32'd1;
                  end
                  `CMD_WRITE: begin
                     th_nxt = LINK.cmd_data[`DATA_TH_HI:`DATA_TH_LO];
                     tl_nxt = LINK.cmd_data[`DATA_TL_HI:`DATA_TL_LO];
                     cfg_nxt = LINK.cmd_data[`DATA_CFG_HI:`DATA_CFG_LO];
                  end
                  `CMD_READ: begin
                     // The answer is registered, so it follows the command by one cycle.
                     rsp_vld_nxt = 1'b1;
                     rsp_data_nxt = {24'h0, temp_r, th_r, tl_r, cfg_r}; // R9
                  end
                  default: begin
                     state_nxt = D_IDLE;
                  end
               endcase
            end
         end
         // Commands that arrive while busy are dropped without an answer.
         D_CONV, D_COPY: begin
            // Without the strong pullup the operation cannot be powered.
            if (!LINK.spu_en) begin // R2
               fault_nxt = 1'b1;
               state_nxt = D_IDLE;
            end else if (cnt_r == 32'd0) begin
               state_nxt = D_IDLE; // R10
               if (state_r == D_CONV) begin
                  temp_nxt = sample; // R9
                  alarm_nxt = alarm_hit; // R7
               end else begin
                  // The nonvolatile copies change only at the end of a fully powered copy.
                  ee_th_nxt = th_r; // R8
                  ee_tl_nxt = tl_r; // R8
                  ee_cfg_nxt = cfg_r; // R11
               end
            end else begin
               cnt_nxt = cnt_r - 32'd1;
            end
         end
         default: begin
            state_nxt = D_IDLE;
         end
      endcase
   end

   // ==========================================================
   // Registers
   // The nonvolatile copies are plain registers, so a reset brings back their power-up values
   // rather than the last copied ones; no command recalls them into the scratchpad.
   always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         state_r <= D_IDLE;
         cnt_r <= 32'h0;
         temp_r <= `TEMP_RST;
         th_r <= `TH_RST;
         tl_r <= `TL_RST;
         cfg_r <= `CFG_RST;
         ee_th_r <= `TH_RST;
         ee_tl_r <= `TL_RST;
         ee_cfg_r <= `CFG_RST;
         alarm_r <= 1'b0;
         fault_r <= 1'b0;
         rsp_vld_r <= 1'b0;
         rsp_data_r <= 64'h0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         temp_r <= temp_nxt;
         th_r <= th_nxt;
         tl_r <= tl_nxt;
         cfg_r <= cfg_nxt;
         ee_th_r <= ee_th_nxt;
         ee_tl_r <= ee_tl_nxt;
         ee_cfg_r <= ee_cfg_nxt;
         alarm_r <= alarm_nxt;
         fault_r <= fault_nxt;
         rsp_vld_r <= rsp_vld_nxt;
         rsp_data_r <= rsp_data_nxt;
      end
   end

   // ==========================================================
   // Outputs
   assign LINK.rsp_vld = rsp_vld_r;
   assign LINK.rsp_data = rsp_data_r;
   // Busy covers both long operations, so a master may watch it instead of counting.
   assign BUSY_O = (state_r != D_IDLE);
   assign ALARM_O = alarm_r;
   assign POWER_FAULT_O = fault_r;
   assign TEMP_O = temp_r;
endmodule // ppl_sensor_dev
`default_nettype wire

// *** rtl/ppl_bus_master.sv ***
// Bus master end of the link with strong pullup sequencing.
`include "ppl_consts.svh"
`default_nettype none
module ppl_bus_master #(
   parameter int unsigned CONV_CYC = `CONV_CYC,
   parameter int unsigned COPY_CYC = `COPY_CYC
) (
   input wire logic CORE_CLK_I,
   input wire logic NRST_I,
   ppl_link_if.master_mp LINK,
   input wire logic REQ_VLD_I,
   input wire ppl_pkg::cmd_t REQ_CODE_I,
   input wire ppl_pkg::rom_t REQ_ROM_I,
   input wire logic [23:0] REQ_DATA_I,
   output logic REQ_RDY_O,
   output logic RSP_VLD_O,
   output logic RSP_NONE_O,
   output logic [63:0] RSP_DATA_O,
   output logic OP_DONE_O
);
   import ppl_pkg::*;

   // ==========================================================
   // State
   mst_state_t state_r, state_nxt;
   logic [31:0] cnt_r, cnt_nxt;
   cmd_t code_r, code_nxt;
   rom_t rom_r, rom_nxt;
   logic [23:0] data_r, data_nxt;
   res_t res_r, res_nxt;
   logic spu_r, spu_nxt;
   logic rsp_vld_r, rsp_vld_nxt;
   logic rsp_none_r, rsp_none_nxt;
   logic [63:0] rsp_data_r, rsp_data_nxt;
   logic done_r, done_nxt;

   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      code_nxt = code_r;
      rom_nxt = rom_r;
      data_nxt = data_r;
      res_nxt = res_r;
      spu_nxt = spu_r;
      rsp_vld_nxt = 1'b0;
      rsp_none_nxt = 1'b0;
      rsp_data_nxt = rsp_data_r;
      done_nxt = 1'b0;
      case (state_r)
         M_IDLE: begin
            if (REQ_VLD_I) begin
               code_nxt = REQ_CODE_I;
               rom_nxt = REQ_ROM_I;
               data_nxt = REQ_DATA_I;
               state_nxt = M_SEND;
            end
         end
         M_SEND: begin
            state_nxt = M_IDLE;
            done_nxt = 1'b1;
            if (code_r == `CMD_CONVERT || code_r == `CMD_COPY) begin
               // Pullup comes on the cycle after the command, far inside the deadline.
               spu_nxt = 1'b1; // R1
               state_nxt = M_HOLD;
               done_nxt = 1'b0;
               cnt_nxt = (code_r == `CMD_CONVERT) ? conv_cycles(CONV_CYC, res_r) : COPY_CYC; // R2
            end else if (code_r == `CMD_READ || code_r == `CMD_ALARM) begin
               state_nxt = M_WAIT;
               done_nxt = 1'b0;
               cnt_nxt = `RSP_WAIT_CYC;
            end else if (code_r == `CMD_WRITE) begin
               res_nxt = data_r[`CFG_RES_HI:`CFG_RES_LO];
            end
         end
         M_HOLD: begin
            if (cnt_r == 32'd1) begin
               spu_nxt = 1'b0; // R12
               done_nxt = 1'b1;
               state_nxt = M_IDLE;
            end else begin
               cnt_nxt = cnt_r - 32'd1; // R2
            end
         end
         M_WAIT: begin
            if (LINK.rsp_vld) begin
               rsp_vld_nxt = 1'b1;
               rsp_data_nxt = LINK.rsp_data;
               done_nxt = 1'b1;
               state_nxt = M_IDLE;
            end else if (cnt_r == 32'd1) begin
               rsp_vld_nxt = 1'b1;
               rsp_none_nxt = 1'b1;
               done_nxt = 1'b1;
               state_nxt = M_IDLE;
            end else begin
               cnt_nxt = cnt_r - 32'd1;
            end
         end
         default: begin
            state_nxt = M_IDLE;
         end
      endcase
   end

   always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         state_r <= M_IDLE;
         cnt_r <= 32'h0;
         code_r <= 8'h0;
         rom_r <= 64'h0;
         data_r <= 24'h0;
         res_r <= 2'h3;
         spu_r <= 1'b0;
         rsp_vld_r <= 1'b0;
         rsp_none_r <= 1'b0;
         rsp_data_r <= 64'h0;
         done_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         code_r <= code_nxt;
         rom_r <= rom_nxt;
         data_r <= data_nxt;
         res_r <= res_nxt;
         spu_r <= spu_nxt;
         rsp_vld_r <= rsp_vld_nxt;
         rsp_none_r <= rsp_none_nxt;
         rsp_data_r <= rsp_data_nxt;
         done_r <= done_nxt;
      end
   end

   // ==========================================================
   // Outputs
   assign REQ_RDY_O = (state_r == M_IDLE); // R3
   assign LINK.cmd_vld = (state_r == M_SEND); // R3
   assign LINK.cmd_code = code_r;
   assign LINK.cmd_rom = rom_r; // R4
   assign LINK.cmd_data = data_r;
   assign LINK.spu_en = spu_r;
   assign RSP_VLD_O = rsp_vld_r;
   assign RSP_NONE_O = rsp_none_r;
   assign RSP_DATA_O = rsp_data_r;
   assign OP_DONE_O = done_r;
endmodule // ppl_bus_master
`default_nettype wire

// *** testbench/ppl_link_checker.sv ***
// Assertions on the command link between the bus master and the sensor.
`include "ppl_consts.svh"
`default_nettype none
module ppl_link_checker #(
   parameter logic [63:0] ROM_ID = 64'h0,
   parameter int unsigned CONV_CYC = 64,
   parameter int unsigned COPY_CYC = 16
) (
   input wire logic CORE_CLK_I,
   input wire logic NRST_I,
   input wire logic cmd_vld,
   input wire ppl_pkg::cmd_t cmd_code,
   input wire ppl_pkg::rom_t cmd_rom,
   input wire logic [23:0] cmd_data,
   input wire logic spu_en,
   input wire logic rsp_vld,
   input wire logic [63:0] rsp_data
);
   import ppl_pkg::*;
   res_t res_r, res_nxt;
   logic [31:0] exp_r, exp_nxt, hold_r, hold_nxt;
   logic sel;
   // ==========================================
   // Helper state: resolution and expected hold.
   assign sel = cmd_vld && cmd_rom == ROM_ID;
   always_comb begin
      res_nxt = res_r;
      exp_nxt = exp_r;
      hold_nxt = spu_en ? hold_r + 32'h1 : 32'h0;
      if (sel && cmd_code == `CMD_WRITE) res_nxt = cmd_data[6:5];
      if (cmd_vld && cmd_code == `CMD_CONVERT) exp_nxt = CONV_CYC >> (2'd3 - res_r);
      if (cmd_vld && cmd_code == `CMD_COPY) exp_nxt = COPY_CYC;
   end
   always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         res_r <= 2'h3;
         exp_r <= 32'h0;
         hold_r <= 32'h0;
      end else begin
         res_r <= res_nxt;
         exp_r <= exp_nxt;
         hold_r <= hold_nxt;
      end
   end
   // ==========================================
   // Properties.
   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (!NRST_I);
   sequence spu_cmd_s;
      cmd_vld && (cmd_code == `CMD_CONVERT || cmd_code == `CMD_COPY);
   endsequence
   sequence spu_release_s;
      spu_en ##1 !spu_en;
   endsequence
   spu_on_a: assert property (spu_cmd_s |=> spu_en) else $error("pullup late");
   hold_len_a: assert property (spu_release_s |-> hold_r == exp_r) else $error("hold length");
   spu_quiet_a: assert property (spu_en |-> !cmd_vld) else $error("traffic under pullup");
   spu_cause_a: assert property ($rose(spu_en) |-> $past(cmd_vld) && ($past(cmd_code) == `CMD_CONVERT
      || $past(cmd_code) == `CMD_COPY)) else $error("pullup without cause");
   read_answer_a: assert property (sel && cmd_code == `CMD_READ |=> rsp_vld) else $error("no read answer");
   read_skip_a: assert property (cmd_vld && cmd_code == `CMD_READ && !sel |=> !rsp_vld)
      else $error("wrong device answered");
   rsp_cause_a: assert property (rsp_vld |-> $past(cmd_vld)) else $error("unsolicited answer");
   read_fmt_a: assert property (rsp_vld && $past(cmd_code) == `CMD_READ |-> rsp_data[63:40] == 24'h0
      && rsp_data[6:5] == res_r) else $error("read format");
endmodule // ppl_link_checker
`default_nettype wire

// *** testbench/parasite_power_sensor_link_tb.sv ***
// Testbench joining the bus master and the sensor across the link.
`include "ppl_consts.svh"
`default_nettype none
module parasite_power_sensor_link_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import ppl_pkg::*;
   localparam logic [63:0] ROM = 64'h5a5a00001234c3a5; // Arbitrary device code.
   localparam int unsigned CONV = 64;
   localparam int unsigned COPY = 16;
   logic clk, nrst, req_vld, rdy, rsp_vld, rsp_none, done, busy, alarm, fault, busy2, fault2, none_seen;
   cmd_t req_code;
   rom_t req_rom;
   logic [23:0] req_data;
   logic [63:0] rsp_data, data_seen;
   logic [15:0] sens, temp;
   int fail_count, compares, cyc;
   ppl_link_if link();
   ppl_link_if link2();
   ppl_bus_master #(.CONV_CYC(CONV), .COPY_CYC(COPY)) u_ppl_bus_master (.CORE_CLK_I(clk), .NRST_I(nrst),
      .LINK(link), .REQ_VLD_I(req_vld), .REQ_CODE_I(req_code), .REQ_ROM_I(req_rom), .REQ_DATA_I(req_data),
      .REQ_RDY_O(rdy), .RSP_VLD_O(rsp_vld), .RSP_NONE_O(rsp_none), .RSP_DATA_O(rsp_data), .OP_DONE_O(done));
   ppl_sensor_dev #(.ROM_ID(ROM), .CONV_CYC(CONV), .COPY_CYC(COPY)) u_ppl_sensor_dev (.CORE_CLK_I(clk),
      .NRST_I(nrst), .LINK(link), .SENSOR_I(sens), .BUSY_O(busy), .ALARM_O(alarm), .POWER_FAULT_O(fault),
      .TEMP_O(temp));
   // This second device faces the bench, which withholds the strong pullup.
   ppl_sensor_dev #(.ROM_ID(ROM), .CONV_CYC(CONV), .COPY_CYC(COPY)) u_ppl_sensor_dev2 (.CORE_CLK_I(clk),
      .NRST_I(nrst), .LINK(link2), .SENSOR_I(sens), .BUSY_O(busy2), .ALARM_O(), .POWER_FAULT_O(fault2),
      .TEMP_O());
   ppl_link_checker #(.ROM_ID(ROM), .CONV_CYC(CONV), .COPY_CYC(COPY)) u_ppl_link_checker (.CORE_CLK_I(clk),
      .NRST_I(nrst), .cmd_vld(link.cmd_vld), .cmd_code(link.cmd_code), .cmd_rom(link.cmd_rom),
      .cmd_data(link.cmd_data), .spu_en(link.spu_en), .rsp_vld(link.rsp_vld), .rsp_data(link.rsp_data));
   // ==========================================
   // Tasks.
   task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic give_verdict;
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Issues one request and counts edges from acceptance to the done pulse.
   task automatic req(input cmd_t code, input rom_t rom, input logic [23:0] data);
      req_vld <= 1'b1;
      req_code <= code;
      req_rom <= rom;
      req_data <= data;
      do @(posedge clk); while (rdy !== 1'b1);
      req_vld <= 1'b0;
      cyc = 0;
      none_seen = 1'bx;
      data_seen = 64'hx;
      do begin
         @(posedge clk);
         cyc++;
         if (rsp_vld === 1'b1) begin
            none_seen = rsp_none;
            data_seen = rsp_data;
         end
      end while (done !== 1'b1 && cyc < 300);
   endtask
   // ==========================================
   // Clock, watchdog and tests.
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      #50000;
      fail_count++;
      give_verdict();
   end
   initial begin
      nrst = 1'b0;
      req_vld = 1'b0;
      req_code = 8'h00;
      req_rom = 64'h0;
      req_data = 24'h0;
      sens = 16'h01a7;
      link2.cmd_vld = 1'b0;
      link2.cmd_code = 8'h00;
      link2.cmd_rom = ROM;
      link2.cmd_data = 24'h0;
      link2.spu_en = 1'b0;
      fail_count = 0;
      compares = 0;
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      check("temp_rst", {48'h0, temp}, 64'h0550);
      check("idle", {61'h0, busy, alarm, rdy}, 64'h1);
      req(`CMD_READ, ROM, 24'h0);
      check("read_rst", data_seen, {24'h0, 16'h0550, 8'h7f, 8'h80, 8'h60});
      for (int r = 0; r < 4; r++) begin
         req(`CMD_WRITE, ROM, {8'h20, 8'hf0, 1'b0, 2'(r), 5'h00});
         check("write_cyc", 64'(cyc), 64'd2);
         req(`CMD_CONVERT, ROM, 24'h0);
         check("conv_cyc", 64'(cyc), 64'(2 + (CONV >> (3 - r))));
         check("temp_res", {48'h0, temp}, {48'h0, sens & ~((16'h1 << (3 - r)) - 16'h1)});
         check("no_alarm", {63'h0, alarm}, 64'h0);
         check("no_fault", {63'h0, fault}, 64'h0);
      end
      req(`CMD_READ, ROM, 24'h0);
      check("read_back", data_seen, {24'h0, 16'h01a7, 8'h20, 8'hf0, 8'h60});
      req(`CMD_ALARM, 64'h0, 24'h0);
      check("search_none", {63'h0, none_seen}, 64'h1);
      req(`CMD_WRITE, ROM, 24'h10f060);
      req(`CMD_CONVERT, ROM, 24'h0);
      check("alarm", {63'h0, alarm}, 64'h1);
      req(`CMD_ALARM, 64'h0, 24'h0);
      check("search_hit", data_seen, ROM);
      req(`CMD_READ, ~ROM, 24'h0);
      check("wrong_rom", {63'h0, none_seen}, 64'h1);
      req(`CMD_COPY, ROM, 24'h0);
      check("copy_cyc", 64'(cyc), 64'(2 + COPY));
      link2.cmd_code <= `CMD_CONVERT;
      link2.cmd_vld <= 1'b1;
      @(posedge clk);
      link2.cmd_vld <= 1'b0;
      repeat (4) @(posedge clk);
      check("fault", {62'h0, fault2, busy2}, 64'h2);
      give_verdict();
   end
endmodule // parasite_power_sensor_link_tb
`default_nettype wire
